// ### logic/riomtl_if.sv
// Connection between the master table loader and the setup program side.
`default_nettype none
interface riomtl_if;
	import riomtl_pkg::*;
	logic            rd_req;
	logic [15:0]     rd_addr;
	logic            rd_valid;
	riomtl_word_type rd_data;
	logic            setup_done_relay;
	logic            baud_high;
	logic            poll_strobe;
	logic [2:0]      poll_station;
	logic [2:0]      own_station;
	modport master (
		output rd_req,
		output rd_addr,
		input  rd_valid,
		input  rd_data,
		input  setup_done_relay,
		input  baud_high,
		output poll_strobe,
		output poll_station,
		output own_station
	);
	modport setup (
		input  rd_req,
		input  rd_addr,
		output rd_valid,
		output rd_data,
		output setup_done_relay,
		output baud_high,
		input  poll_strobe,
		input  poll_station,
		input  own_station
	);
endinterface : riomtl_if
`default_nettype wire

// ### logic/riomtl_master_end.sv
// Master end: loads the remote I/O configuration table and polls the slaves it finds.
//
// Summary of operation
// R1 - Each slave has a unique station 1-7.
// R2 - One master only, always station 0.
// R3 - Slaves use the master's selected baud rate.
// R4 - Table base comes from port setup address.
// R5 - Table is four-word blocks, one per slave.
// R6 - First four words reserved; slave 1 follows.
// R7 - Block order: in addr, in count, out addr, count.
// R8 - Table is always exactly 32 words long.
// R9 - Setup program zeroes unused slave blocks.
// R10 - Non-zero block means slave present; zero absent.
// R11 - Table is loaded only once after powerup.
// R12 - Setup program fills table once, before done.
// R13 - Polling starts only after setup-done relay.
// R14 - Link runs at 19200 or 38400 baud.
// R15 - At most seven bases and 2048 points.
// R16 - Station n block sits at word 4n.
`default_nettype none
module riomtl_master_end
	import riomtl_pkg::*;
(
	input  wire logic        core_clk,
	input  wire logic        nrst,
	riomtl_if.master         link,
	input  wire logic [15:0] table_base,
	input  wire logic [4:0]  cfg_index,
	output var  logic [15:0] cfg_word,
	output var  logic [6:0]  present_mask,
	output var  logic        loaded,
	output var  logic        cfg_error
);
	// ---------------------------------------------------------------
	// Station search
	// ---------------------------------------------------------------
	// Searching onward from the current station keeps the round robin fair.
	function automatic logic [2:0] riomtl_next_station(
		input logic [6:0] mask,
		input logic [2:0] cur
	);
		logic [2:0] cand;
		logic [2:0] found;
		logic       hit;
		cand  = cur;
		found = cur;
		hit   = 1'b0;
		for (int k = 0; k < 7; k++)
		begin
			cand = (cand == LAST_STATION) ? 3'h1 : cand + 3'h1; // R1
			if (!hit && mask[cand - 3'h1])
			begin
				found = cand;
				hit   = 1'b1;
			end
		end
		return found;
	endfunction : riomtl_next_station

	// ---------------------------------------------------------------
	// Load sequencing
	// ---------------------------------------------------------------
	riomtl_mst_state_type state;
	logic [4:0]           load_idx;
	logic [19:0]          pts_sum;
	riomtl_word_type      cfg_mem [0:31];
	logic [10:0]          div_cnt;
	logic [3:0]           bit_cnt;
	wire  logic [2:0]     load_station;
	wire  logic [1:0]     load_field;
	wire  logic           is_count;
	wire  logic           store;
	wire  logic [10:0]    div_last;
	wire  logic           bit_tick;
	wire  logic           frame_tick;
	wire  logic [2:0]     next_poll;

	assign load_station = load_idx[4:2]; // R16
	assign load_field   = load_idx[1:0]; // R5 R7
	assign is_count     = (load_field == FLD_IN_CNT) || (load_field == FLD_OUT_CNT); // R7
	// Reads go one at a time, so an answer always belongs to the current index.
	assign store        = (state == MST_LOAD_WAIT) && link.rd_valid;
	assign link.rd_req  = (state == MST_LOAD_REQ);
	assign link.rd_addr = table_base + {11'h000, load_idx}; // R4
	assign link.own_station = MASTER_STATION; // R2
	assign div_last     = link.baud_high ? DIV_HIGH_CNT : DIV_LOW_CNT; // R14 R3
	// A baud change in mid-count must not let the divider run past its end.
	assign bit_tick     = (div_cnt >= div_last);
	assign frame_tick   = bit_tick && (bit_cnt == POLL_BITS_LAST);
	assign next_poll    = riomtl_next_station(present_mask, link.poll_station);

	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			state        <= MST_WAIT_SETUP;
			load_idx     <= TBL_FIRST_SLAVE_IDX;
			pts_sum      <= 20'h00000;
			present_mask <= 7'h00;
			loaded       <= 1'b0;
			cfg_error    <= 1'b0;
		end
		else
		begin
			case (state)
				MST_WAIT_SETUP:
				begin
					if (link.setup_done_relay)
						state <= MST_LOAD_REQ; // R13 R11
				end
				MST_LOAD_REQ: state <= MST_LOAD_WAIT;
				MST_LOAD_WAIT:
				begin
					if (store)
					begin
						if (link.rd_data != WORD_RESET)
							present_mask[load_station - 3'h1] <= 1'b1; // R10
						if (is_count)
							pts_sum <= pts_sum + {4'h0, link.rd_data}; // R15
						if (load_idx == TBL_LAST_IDX)
							state <= MST_CHECK; // R8
						else
						begin
							load_idx <= load_idx + 5'h01;
							state    <= MST_LOAD_REQ;
						end
					end
				end
				MST_CHECK:
				begin
					// A channel over budget is never polled rather than served partly.
					if (pts_sum > MAX_CHANNEL_POINTS)
					begin
						cfg_error <= 1'b1; // R15
						state     <= MST_HALT;
					end
					else
					begin
						loaded <= 1'b1;
						state  <= MST_POLL;
					end
				end
				MST_POLL: state <= MST_POLL; // R11
				MST_HALT: state <= MST_HALT;
				default:  state <= MST_WAIT_SETUP;
			endcase
		end
	end

	// ---------------------------------------------------------------
	// Table copy and readback
	// ---------------------------------------------------------------
	genvar gi;
	generate
		for (gi = 4; gi < 32; gi++)
		begin : g_cfg
			always_ff @(posedge core_clk or negedge nrst)
			begin
				if (!nrst)
					cfg_mem[gi] <= WORD_RESET;
				else if (store && load_idx == 5'(gi))
					cfg_mem[gi] <= link.rd_data; // R6
			end
		end
		// Reserved words read back as zero whatever the setup program left there.
		for (gi = 0; gi < 4; gi++)
		begin : g_rsvd
			assign cfg_mem[gi] = WORD_RESET; // R6
		end
	endgenerate

	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
			cfg_word <= WORD_RESET;
		else
			cfg_word <= cfg_mem[cfg_index];
	end

	// ---------------------------------------------------------------
	// Poll pacing
	// ---------------------------------------------------------------
	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			div_cnt           <= 11'h000;
			bit_cnt           <= 4'h0;
			link.poll_strobe  <= 1'b0;
			link.poll_station <= MASTER_STATION;
		end
		else
		begin
			// The divider runs free, so the first poll comes within one frame of loading.
			div_cnt          <= bit_tick ? 11'h000 : div_cnt + 11'h001;
			link.poll_strobe <= 1'b0;
			if (bit_tick)
				bit_cnt <= (bit_cnt == POLL_BITS_LAST) ? 4'h0 : bit_cnt + 4'h1;
			if (state == MST_POLL && frame_tick && present_mask != 7'h00)
			begin
				link.poll_strobe  <= 1'b1; // R13
				link.poll_station <= next_poll; // R1 R15
			end
		end
	end
endmodule : riomtl_master_end
`default_nettype wire

// ### logic/riomtl_pkg.sv
// Shared constants and types for the remote I/O master table loader.
`default_nettype none
package riomtl_pkg;
	// ---------------------------------------------------------------
	// Table layout
	// ---------------------------------------------------------------
	localparam logic [15:0] DEFAULT_TABLE_BASE  = 16'h3FC0; // Octal 37700.
	localparam logic [4:0]  TBL_FIRST_SLAVE_IDX = 5'h04;
	localparam logic [4:0]  TBL_LAST_IDX        = 5'h1F;
	localparam logic [5:0]  TBL_WORDS           = 6'h20;
	localparam logic [1:0]  FLD_IN_ADDR         = 2'h0;
	localparam logic [1:0]  FLD_IN_CNT          = 2'h1;
	localparam logic [1:0]  FLD_OUT_ADDR        = 2'h2;
	localparam logic [1:0]  FLD_OUT_CNT         = 2'h3;
	localparam logic [15:0] WORD_RESET          = 16'h0000;
	// ---------------------------------------------------------------
	// Stations and channel limits
	// ---------------------------------------------------------------
	localparam logic [2:0]  MASTER_STATION      = 3'h0;
	localparam logic [2:0]  LAST_STATION        = 3'h7;
	localparam logic [19:0] MAX_CHANNEL_POINTS  = 20'h00800;
	// ---------------------------------------------------------------
	// Timing
	// ---------------------------------------------------------------
	localparam int          CLK_HZ              = 25000000;
	localparam int          BAUD_LOW            = 19200;
	localparam int          BAUD_HIGH           = 38400;
	localparam logic [10:0] DIV_LOW_CNT         = 11'(CLK_HZ / BAUD_LOW - 1);
	localparam logic [10:0] DIV_HIGH_CNT        = 11'(CLK_HZ / BAUD_HIGH - 1);
	localparam logic [3:0]  POLL_BITS_LAST      = 4'hA;
	// ---------------------------------------------------------------
	// Types
	// ---------------------------------------------------------------
	typedef logic [15:0] riomtl_word_type;
	typedef enum logic [2:0] {
		MST_WAIT_SETUP = 3'b000,
		MST_LOAD_REQ   = 3'b001,
		MST_LOAD_WAIT  = 3'b010,
		MST_CHECK      = 3'b011,
		MST_POLL       = 3'b100,
		MST_HALT       = 3'b101
	} riomtl_mst_state_type;
	typedef enum logic [1:0] {
		SET_FILL = 2'b00,
		SET_ZERO = 2'b01,
		SET_DONE = 2'b10
	} riomtl_set_state_type;
endpackage : riomtl_pkg
`default_nettype wire

// ### logic/riomtl_setup_end.sv
// Setup program end: holds the configuration table and raises the setup-done relay.
`default_nettype none
module riomtl_setup_end
	import riomtl_pkg::*;
(
	input  wire logic       core_clk,
	input  wire logic       nrst,
	riomtl_if.setup         link,
	input  wire logic [15:0] table_base,
	input  wire logic       baud_high_sel,
	input  wire logic       fill_wr,
	input  wire logic [4:0] fill_index,
	input  wire logic [15:0] fill_data,
	input  wire logic [2:0] slave_count,
	input  wire logic       fill_finish,
	output var  logic       setup_done
);
	// ---------------------------------------------------------------
	// Fill sequencing
	// ---------------------------------------------------------------
	riomtl_set_state_type state;
	logic [5:0]           zero_idx;
	riomtl_word_type      table_mem [0:31];
	wire  logic           wr_en;
	wire  logic [4:0]     wr_idx;
	wire  riomtl_word_type wr_data;
	wire  logic [5:0]     zero_start;
	wire  logic [15:0]    rd_off;
	wire  logic           rd_in_range;

	assign wr_en       = (state == SET_FILL && fill_wr) // R12
		|| (state == SET_ZERO && zero_idx < TBL_WORDS); // R9
	assign wr_idx      = (state == SET_ZERO) ? zero_idx[4:0] : fill_index;
	assign wr_data     = (state == SET_ZERO) ? WORD_RESET : fill_data;
	assign zero_start  = {slave_count, 2'b00} + {1'b0, TBL_FIRST_SLAVE_IDX}; // R1 R9
	assign rd_off      = link.rd_addr - table_base;
	assign rd_in_range = rd_off < {10'h000, TBL_WORDS};
	assign link.setup_done_relay = (state == SET_DONE); // R13
	assign link.baud_high        = baud_high_sel; // R3 R14

	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			state    <= SET_FILL;
			zero_idx <= 6'h00;
		end
		else
		begin
			case (state)
				SET_FILL:
				begin
					if (fill_finish)
					begin
						zero_idx <= zero_start;
						state    <= SET_ZERO;
					end
				end
				SET_ZERO:
				begin
					// Unused blocks must read as zero or the master takes them as slaves.
					if (zero_idx >= TBL_WORDS - 6'h01)
						state <= SET_DONE;
					else
						zero_idx <= zero_idx + 6'h01; // R9
				end
				SET_DONE: state <= SET_DONE; // R12
				default:  state <= SET_FILL;
			endcase
		end
	end

	// ---------------------------------------------------------------
	// Table storage and read port
	// ---------------------------------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < 32; gi++)
		begin : g_word
			always_ff @(posedge core_clk or negedge nrst)
			begin
				if (!nrst)
					table_mem[gi] <= WORD_RESET;
				else if (wr_en && wr_idx == 5'(gi))
					table_mem[gi] <= wr_data;
			end
		end
	endgenerate

	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			link.rd_valid <= 1'b0;
			link.rd_data  <= WORD_RESET;
			setup_done    <= 1'b0;
		end
		else
		begin
			link.rd_valid <= link.rd_req;
			link.rd_data  <= rd_in_range ? table_mem[rd_off[4:0]] : WORD_RESET;
			setup_done    <= (state == SET_DONE);
		end
	end
endmodule : riomtl_setup_end
`default_nettype wire

// ### test/riomtl_props.sv
// Concurrent checks on the link between the two ends.
`default_nettype none
module riomtl_props
	import riomtl_pkg::*;
(
	input wire logic            core_clk,
	input wire logic            nrst,
	input wire logic            rd_req,
	input wire logic [15:0]     rd_addr,
	input wire logic            rd_valid,
	input wire riomtl_word_type rd_data,
	input wire logic            setup_done_relay,
	input wire logic            baud_high,
	input wire logic            poll_strobe,
	input wire logic [2:0]      poll_station,
	input wire logic [2:0]      own_station
);
	timeunit 1ns;
	timeprecision 1ns;
	// ------------
	// Read counter
	// ------------
	// Counting reads lets two checks prove the load is once and whole.
	logic [5:0] n_rd;
	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
			n_rd <= 6'h00;
		else if (rd_req)
			n_rd <= n_rd + 6'h01;
	end
	default clocking @(posedge core_clk); endclocking
	default disable iff (!nrst);
	sequence s_read_pair;
		rd_req ##2 rd_req;
	endsequence
	sequence s_relay_up;
		$rose(setup_done_relay);
	endsequence
	// ----------
	// Properties
	// ----------
	a_master_addr: assert property (
		own_station == MASTER_STATION) else $error("master station not zero");
	a_no_early: assert property (
		!setup_done_relay |-> !rd_req && !poll_strobe) else $error("activity before relay");
	a_start_load: assert property (
		s_relay_up |-> ##[0:4] rd_req) else $error("load did not start");
	a_req_gap: assert property (
		rd_req |=> !rd_req && rd_valid) else $error("read spacing or answer wrong");
	a_read_step: assert property (
		s_read_pair |-> rd_addr == $past(rd_addr, 2) + 16'h0001) else $error("read step wrong");
	a_read_count: assert property (
		n_rd <= 6'h1C) else $error("too many table reads");
	a_poll_late: assert property (
		poll_strobe |-> n_rd == 6'h1C) else $error("poll before full load");
	a_poll_legal: assert property (
		poll_strobe |-> poll_station != MASTER_STATION) else $error("poll of station zero");
	a_relay_holds: assert property (
		setup_done_relay |=> setup_done_relay) else $error("relay dropped");
endmodule : riomtl_props
`default_nettype wire

// ### test/test_remote_io_master_table_loader.sv
// Self-checking bench for the table loader pair.
`default_nettype none
module test_remote_io_master_table_loader
	import riomtl_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic core_clk, nrst, baud_high_sel, fill_wr, fill_finish;
	logic [15:0] table_base, fill_data;
	logic [4:0] fill_index, cfg_index;
	logic [2:0] slave_count;
	logic [15:0] cfg_word;
	logic [6:0] present_mask;
	logic loaded, cfg_error, setup_done;
	int n_mismatch, cmp_count;
	riomtl_word_type exp_t [32];
	riomtl_if lnk();
	riomtl_setup_end riomtl_setup_end_i(.core_clk, .nrst, .link(lnk), .table_base,
		.baud_high_sel, .fill_wr, .fill_index, .fill_data, .slave_count, .fill_finish,
		.setup_done);
	riomtl_master_end riomtl_master_end_i(.core_clk, .nrst, .link(lnk), .table_base,
		.cfg_index, .cfg_word, .present_mask, .loaded, .cfg_error);
	riomtl_props riomtl_props_i(.core_clk, .nrst, .rd_req(lnk.rd_req),
		.rd_addr(lnk.rd_addr), .rd_valid(lnk.rd_valid), .rd_data(lnk.rd_data),
		.setup_done_relay(lnk.setup_done_relay), .baud_high(lnk.baud_high),
		.poll_strobe(lnk.poll_strobe), .poll_station(lnk.poll_station),
		.own_station(lnk.own_station));
	always #20 core_clk = ~core_clk;
	// -------
	// Helpers
	// -------
	task tick;
		@(posedge core_clk);
		#1;
	endtask : tick
	task check(input logic [15:0] seen, input logic [15:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task fill(input logic [4:0] i, input logic [15:0] d);
		fill_wr = 1'b1;
		fill_index = i;
		fill_data = d;
		if (i >= 5'h04)
			exp_t[i] = d;
		tick;
	endtask : fill
	task do_reset;
		nrst = 1'b0;
		foreach (exp_t[k])
			exp_t[k] = 16'h0000;
		repeat (2) @(posedge core_clk);
		#1 nrst = 1'b1;
		tick;
	endtask : do_reset
	task finish_fill(input logic [2:0] c);
		fill_wr = 1'b0;
		slave_count = c;
		for (int k = 4 * (c + 1); k < 32; k++)
			exp_t[k] = 16'h0000;
		repeat (20) tick;
		check(16'(lnk.setup_done_relay), 16'h0000);
		check(16'(setup_done), 16'h0000);
		check(16'(loaded), 16'h0000);
		fill_finish = 1'b1;
		tick;
		fill_finish = 1'b0;
		for (int k = 0; k < 200 && loaded !== 1'b1 && cfg_error !== 1'b1; k++)
			tick;
		check(16'(setup_done), 16'h0001);
	endtask : finish_fill
	task wait_poll(input logic [15:0] st);
		int k;
		k = 0;
		do
		begin
			tick;
			k++;
		end
		while (lnk.poll_strobe !== 1'b1 && k < 8000);
		check(16'(lnk.poll_strobe), 16'h0001);
		check(16'(lnk.poll_station), st);
	endtask : wait_poll
	// ---------
	// Scenarios
	// ---------
	task t_load_map;
		table_base = DEFAULT_TABLE_BASE;
		baud_high_sel = 1'b1;
		do_reset;
		check(16'(present_mask), 16'h0000);
		fill(5'h00, 16'hBEEF);
		fill(5'h04, 16'h0040);
		fill(5'h05, 16'h0400);
		fill(5'h06, 16'h0080);
		fill(5'h07, 16'h0200);
		fill(5'h0F, 16'h0200);
		fill(5'h14, 16'h1234);
		finish_fill(3'h3);
		check(16'(loaded), 16'h0001);
		check(16'(present_mask), 16'h0005);
		check(16'(lnk.baud_high), 16'h0001);
		for (int k = 0; k < 32; k++)
		begin
			cfg_index = 5'(k);
			tick;
			check(cfg_word, exp_t[k]);
		end
		fill(5'h04, 16'h7777);
		fill_wr = 1'b0;
		cfg_index = 5'h04;
		repeat (2) tick;
		check(cfg_word, 16'h0040);
		check(16'(lnk.own_station), 16'h0000);
		wait_poll(16'h0001);
		wait_poll(16'h0003);
		wait_poll(16'h0001);
	endtask : t_load_map
	task t_over_budget;
		int n;
		n = 0;
		table_base = 16'h1000;
		baud_high_sel = 1'b0;
		do_reset;
		fill(5'h05, 16'h0400);
		fill(5'h07, 16'h0401);
		finish_fill(3'h1);
		check(16'(cfg_error), 16'h0001);
		check(16'(loaded), 16'h0000);
		cfg_index = 5'h05;
		tick;
		check(cfg_word, 16'h0400);
		repeat (15000)
		begin
			tick;
			if (lnk.poll_strobe !== 1'b0)
				n++;
		end
		check(16'(n), 16'h0000);
	endtask : t_over_budget
	task report_and_stop;
		$display("mismatches %0d, compares %0d", n_mismatch, cmp_count);
		if (n_mismatch == 0 && cmp_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : report_and_stop
	initial
	begin
		core_clk = 1'b0;
		{nrst, baud_high_sel, fill_wr, fill_finish} = 4'h0;
		{table_base, fill_data} = 32'h0000_0000;
		{fill_index, cfg_index, slave_count} = 13'h0000;
		n_mismatch = 0;
		cmp_count = 0;
		t_load_map;
		t_over_budget;
		report_and_stop;
	end
	// The run needs about 37000 cycles; the limit leaves ample margin.
	initial
	begin
		#(60000 * 40);
		n_mismatch++;
		report_and_stop;
	end
endmodule : test_remote_io_master_table_loader
`default_nettype wire
